// ---- cbu_regs.svh ----
// Constants for the condition, branch and integer flag unit.
// Assumes inclusion by bare name from the package and design files.
`ifndef CBU_REGS_SVH
`define CBU_REGS_SVH
// Register offsets (word addresses on the plain register port)
`define CBU_ADDR_CTRL    4'h0
`define CBU_ADDR_STATUS  4'h1
`define CBU_ADDR_IRQ_ST  4'h2
`define CBU_ADDR_IRQ_MSK 4'h3
`define CBU_ADDR_ACC1    4'h4
`define CBU_ADDR_ACC2    4'h5
`define CBU_ADDR_ACC3    4'h6
`define CBU_ADDR_ACC4    4'h7
`define CBU_ADDR_PC      4'h8
// Status word field positions
`define CBU_SW_CC_LO     1
`define CBU_SW_CC_HI     2
`define CBU_SW_AERR      3
`define CBU_SW_SERR      4
`define CBU_SW_LRES      5
// Control fields
`define CBU_CTRL_FOUR    0
// Interrupt event bits
`define CBU_IRQ_AERR     0
`define CBU_IRQ_UNORD    1
`define CBU_IRQ_TAKEN    2
// Reset values
`define CBU_STATUS_RST   16'h0000
`define CBU_PC_RST       16'h0000
`endif

// ---- cbu_pkg.sv ----
// Types for the condition, branch and integer flag unit.
// Assumes cbu_regs.svh is on the include path.
package cbu_pkg;
  `include "cbu_regs.svh"
  typedef enum logic [3:0] {
    CBU_OP_NOP    = 4'h0,
    CBU_OP_ADD16  = 4'h1,
    CBU_OP_JLEZ   = 4'h2,
    CBU_OP_JUNORD = 4'h3,
    CBU_OP_JALWAY = 4'h4,
    CBU_OP_LOOP   = 4'h5,
    CBU_OP_DIV0   = 4'h6,
    CBU_OP_ILLEG  = 4'h7,
    CBU_OP_FUNORD = 4'h8
  } cbu_op_t;
  typedef enum logic [1:0] {
    CBU_ST_IDLE = 2'b00,
    CBU_ST_EXEC = 2'b01
  } cbu_state_t;
endpackage

// ---- cbu_add16.sv ----
// Signed 16-bit adder with condition-code and error classification.
// Assumes pure combinational use by the unit top.
`timescale 1ns/10ps
module cbu_add16 (
  // Operands
  input  wire logic [15:0] a_i,
  input  wire logic [15:0] b_i,
  // Result
  output logic      [15:0] sum_o,
  output logic      [1:0]  cc_o,
  output logic             ovf_o
);
  logic [16:0] wide;
  always_comb begin
    wide  = {a_i[15], a_i} + {b_i[15], b_i};
    sum_o = wide[15:0];
    ovf_o = (wide[16] != wide[15]);
    if (!ovf_o) begin
      if (wide[15:0] == 16'h0000) begin
        cc_o = 2'b00;
      end else if (wide[15]) begin
        cc_o = 2'b01;
      end else begin
        cc_o = 2'b10;
      end
    end else if (wide[16] == 1'b0) begin
      cc_o = 2'b01;
    end else if (wide[15:0] == 16'h0000) begin
      cc_o = 2'b00;
    end else begin
      cc_o = 2'b10;
    end
  end
endmodule

// ---- cbu_unit.sv ----
// Condition branch and integer flag unit: status word, operand stack, pc.
// Assumes one clock domain; commands arrive as one-cycle strobes.
`timescale 1ns/10ps
module cbu_unit
  import cbu_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  // Instruction strobe
  input  wire logic        op_valid_i,
  input  wire logic [3:0]  op_code_i,
  input  wire logic [15:0] op_offset_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Execution results
  output logic      [15:0] pc_o,
  output logic             branch_taken_o,
  output logic             done_o,
  output logic      [15:0] status_o,
  output logic             irq_o
);
  `include "cbu_regs.svh"

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    cbu_state_t  state;
    logic        four_acc;
    logic [15:0] status;
    logic [31:0] acc1;
    logic [31:0] acc2;
    logic [31:0] acc3;
    logic [31:0] acc4;
    logic [15:0] pc;
    logic        taken;
    logic        done;
    logic [2:0]  irq_st;
    logic [2:0]  irq_msk;
    logic        irq;
    logic [31:0] rdata;
    cbu_op_t     op;
    logic [15:0] offset;
  } cbu_state_reg_t;

  cbu_state_reg_t r;
  cbu_state_reg_t next_r;

  logic [15:0] add_sum;
  logic [1:0]  add_cc;
  logic        add_ovf;

  cbu_add16 u_add (
    .a_i   (r.acc1[15:0]),
    .b_i   (r.acc2[15:0]),
    .sum_o (add_sum),
    .cc_o  (add_cc),
    .ovf_o (add_ovf)
  );

  // ****************************************
  // Next state
  // ****************************************
  logic        cc_hi;
  logic        cc_lo;
  logic        go;
  logic [15:0] dec_cnt;
  logic [15:0] seq_pc;
  logic [15:0] tgt_pc;
  logic [2:0]  ev;

  always_comb begin
    next_r  = r;
    cc_hi   = r.status[`CBU_SW_CC_HI];
    cc_lo   = r.status[`CBU_SW_CC_LO];
    go      = 1'b0;
    dec_cnt = r.acc1[15:0] - 16'h0001;
    seq_pc  = r.pc + 16'h0001;
    tgt_pc  = r.pc + r.offset;
    ev      = 3'b000;
    next_r.done  = 1'b0;
    next_r.taken = 1'b0;
    next_r.rdata = 32'h0000_0000;
    case (r.state)
      CBU_ST_IDLE: begin
        if (op_valid_i) begin
          next_r.op     = cbu_op_t'(op_code_i);
          next_r.offset = op_offset_i;
          next_r.state  = CBU_ST_EXEC;
        end
      end
      CBU_ST_EXEC: begin
        next_r.state = CBU_ST_IDLE;
        next_r.done  = 1'b1;
        case (r.op)
          CBU_OP_ADD16: begin
            next_r.acc1[15:0] = add_sum;
            next_r.status[`CBU_SW_CC_HI] = add_cc[1];
            next_r.status[`CBU_SW_CC_LO] = add_cc[0];
            next_r.status[`CBU_SW_AERR]  = add_ovf;
            if (add_ovf) begin
              next_r.status[`CBU_SW_SERR] = 1'b1;
              ev[`CBU_IRQ_AERR] = 1'b1;
            end
            // Logic result bit untouched by addition
            if (r.four_acc) begin
              next_r.acc2 = r.acc3;
              next_r.acc3 = r.acc4;
            end
            // Two-register mode keeps acc2
          end
          CBU_OP_JLEZ: begin
            go = !cc_hi;
          end
          CBU_OP_JUNORD: begin
            go = cc_hi && cc_lo;
          end
          CBU_OP_JALWAY: begin
            go = 1'b1;
          end
          CBU_OP_LOOP: begin
            next_r.acc1[15:0] = dec_cnt;
            go = (dec_cnt != 16'h0000);
          end
          CBU_OP_DIV0, CBU_OP_ILLEG: begin
            next_r.status[`CBU_SW_CC_HI] = 1'b1;
            next_r.status[`CBU_SW_CC_LO] = 1'b1;
            next_r.status[`CBU_SW_AERR]  = 1'b1;
            next_r.status[`CBU_SW_SERR]  = 1'b1;
            ev[`CBU_IRQ_UNORD] = 1'b1;
          end
          CBU_OP_FUNORD: begin
            next_r.status[`CBU_SW_CC_HI] = 1'b1;
            next_r.status[`CBU_SW_CC_LO] = 1'b1;
            ev[`CBU_IRQ_UNORD] = 1'b1;
          end
          default: begin
            next_r.status = r.status;
          end
        endcase
        next_r.pc    = go ? tgt_pc : seq_pc;
        next_r.taken = go;
        ev[`CBU_IRQ_TAKEN] = go;
      end
      default: begin
        next_r.state = CBU_ST_IDLE;
      end
    endcase

    // Register port writes
    if (reg_wr_i) begin
      if (reg_addr_i == `CBU_ADDR_CTRL) begin
        next_r.four_acc = reg_wdata_i[`CBU_CTRL_FOUR];
      end else if (reg_addr_i == `CBU_ADDR_STATUS) begin
        next_r.status = reg_wdata_i[15:0];
      end else if (reg_addr_i == `CBU_ADDR_IRQ_ST) begin
        next_r.irq_st = r.irq_st & ~reg_wdata_i[2:0];
      end else if (reg_addr_i == `CBU_ADDR_IRQ_MSK) begin
        next_r.irq_msk = reg_wdata_i[2:0];
      end else if (reg_addr_i == `CBU_ADDR_ACC1) begin
        next_r.acc1 = reg_wdata_i;
      end else if (reg_addr_i == `CBU_ADDR_ACC2) begin
        next_r.acc2 = reg_wdata_i;
      end else if (reg_addr_i == `CBU_ADDR_ACC3) begin
        next_r.acc3 = reg_wdata_i;
      end else if (reg_addr_i == `CBU_ADDR_ACC4) begin
        next_r.acc4 = reg_wdata_i;
      end else if (reg_addr_i == `CBU_ADDR_PC) begin
        next_r.pc = reg_wdata_i[15:0];
      end
    end
    // Set wins over clear
    next_r.irq_st = next_r.irq_st | ev;
    next_r.irq    = |(next_r.irq_st & next_r.irq_msk);

    // Register port reads
    if (reg_rd_i) begin
      if (reg_addr_i == `CBU_ADDR_CTRL) begin
        next_r.rdata = {31'h0000_0000, r.four_acc};
      end else if (reg_addr_i == `CBU_ADDR_STATUS) begin
        next_r.rdata = {16'h0000, r.status};
      end else if (reg_addr_i == `CBU_ADDR_IRQ_ST) begin
        next_r.rdata = {29'h0000_0000, r.irq_st};
      end else if (reg_addr_i == `CBU_ADDR_IRQ_MSK) begin
        next_r.rdata = {29'h0000_0000, r.irq_msk};
      end else if (reg_addr_i == `CBU_ADDR_ACC1) begin
        next_r.rdata = r.acc1;
      end else if (reg_addr_i == `CBU_ADDR_ACC2) begin
        next_r.rdata = r.acc2;
      end else if (reg_addr_i == `CBU_ADDR_ACC3) begin
        next_r.rdata = r.acc3;
      end else if (reg_addr_i == `CBU_ADDR_ACC4) begin
        next_r.rdata = r.acc4;
      end else if (reg_addr_i == `CBU_ADDR_PC) begin
        next_r.rdata = {16'h0000, r.pc};
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      r        <= '0;
      r.state  <= CBU_ST_IDLE;
      r.op     <= CBU_OP_NOP;
      r.status <= `CBU_STATUS_RST;
      r.pc     <= `CBU_PC_RST;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign reg_rdata_o    = r.rdata;
  assign pc_o           = r.pc;
  assign branch_taken_o = r.taken;
  assign done_o         = r.done;
  assign status_o       = r.status;
  assign irq_o          = r.irq;
endmodule

// ---- cbu_unit_properties.sv ----
// Port checker for the condition, branch and integer flag unit.
// Assumes one clock domain and a bind onto cbu_unit.
`timescale 1ns/10ps
module cbu_props (
  // Clock and commands
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic        op_valid_i,
  input  wire logic [3:0]  op_code_i,
  input  wire logic [15:0] op_offset_i,
  input  wire logic        reg_wr_i,
  // Results
  input  wire logic [15:0] pc_o,
  input  wire logic        branch_taken_o,
  input  wire logic        done_o,
  input  wire logic [15:0] status_o
);
  // ********************************
  // Take tracking and properties
  // ********************************
  logic tk;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      tk <= 1'b0;
    end else if (ce_i) begin
      tk <= op_valid_i && !tk;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_take(hit);
    ce_i && op_valid_i && !tk && hit && !reg_wr_i ##1 !reg_wr_i;
  endsequence
  chk_done_timing: assert property (ce_i && op_valid_i && !tk |-> ##2 done_o)
    else $error("done not two cycles after take");
  chk_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  chk_taken_done: assert property (branch_taken_o |-> done_o)
    else $error("taken without done");
  chk_always_jump: assert property (s_take(op_code_i == 4'h4) |=>
    branch_taken_o && pc_o == $past(pc_o, 2) + $past(op_offset_i, 2))
    else $error("unconditional jump target wrong");
  chk_lez_branch: assert property (s_take(op_code_i == 4'h2) |=>
    branch_taken_o == !$past(status_o[2], 2)) else $error("le-zero decision wrong");
  chk_unord_branch: assert property (s_take(op_code_i == 4'h3) |=>
    branch_taken_o == &$past(status_o[2:1], 2)) else $error("unordered decision wrong");
  chk_branch_status: assert property (s_take(op_code_i inside {[2:5]}) |=>
    status_o == $past(status_o, 2)) else $error("branch changed status");
  chk_code_eleven: assert property (s_take(op_code_i inside {[6:8]}) |=>
    status_o[2:1] == 2'h3) else $error("event did not set code 11");
  chk_pc_linear: assert property (done_o && !branch_taken_o && !$past(reg_wr_i) |->
    pc_o == $past(pc_o) + 16'h0001) else $error("linear step wrong");
  chk_add_logic_bit: assert property (s_take(op_code_i == 4'h1) |=>
    status_o[5] == $past(status_o[5], 2)) else $error("add changed logic result bit");
  chk_add_sticky: assert property (s_take(op_code_i == 4'h1) |=>
    status_o[4] == ($past(status_o[4], 2) || status_o[3])) else $error("sticky flag wrong");
endmodule
bind cbu_unit cbu_props u_props (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
  .op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_offset_i(op_offset_i),
  .reg_wr_i(reg_wr_i), .pc_o(pc_o), .branch_taken_o(branch_taken_o), .done_o(done_o),
  .status_o(status_o));

// ---- cbu_unit_bench.sv ----
// Self-checking bench for the condition, branch and integer flag unit.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
module cbu_unit_bench;
  import cbu_pkg::*;
  logic        mclk_i = 0, rstn_i = 0, op_valid_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic        ce_i = 1;
  logic [3:0]  op_code_i = 0, reg_addr_i = 0;
  logic [15:0] op_offset_i = 0, pc_m = 0, sw = 0, c, pc_o, status_o;
  logic [31:0] reg_wdata_i = 0, reg_rdata_o;
  logic        branch_taken_o, done_o, irq_o;
  int          n_fail = 0, comparisons = 0, s;
  always #10 mclk_i = ~mclk_i;
  cbu_unit uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .op_valid_i(op_valid_i),
    .op_code_i(op_code_i), .op_offset_i(op_offset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pc_o(pc_o), .branch_taken_o(branch_taken_o),
    .done_o(done_o), .status_o(status_o), .irq_o(irq_o));
  // ********************************
  // Shared tasks
  // ********************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    reg_wr_i    <= 1;
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    @(posedge mclk_i);
    reg_wr_i <= 0;
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    reg_rd_i   <= 1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 0;
    #1 chk(reg_rdata_o, e);
  endtask
  task op(input logic [3:0] cd, input logic [15:0] off, input logic t);
    @(posedge mclk_i);
    op_valid_i  <= 1;
    op_code_i   <= cd;
    op_offset_i <= off;
    @(posedge mclk_i);
    op_valid_i <= 0;
    @(posedge mclk_i);
    pc_m = t ? pc_m + off : pc_m + 16'h0001;
    #1 chk(done_o, 1);
    chk(branch_taken_o, t);
    chk(pc_o, pc_m);
    chk(status_o, sw);
  endtask
  task add(input logic [15:0] a, input logic [15:0] b);
    s = int'($signed(a)) + int'($signed(b));
    wr(4'h4, {16'hABCD, a});
    wr(4'h5, {16'h1234, b});
    if (s == -65536) sw[3:1] = 3'h4;
    else if (s > 32767) sw[3:1] = 3'h5;
    else if (s < -32768) sw[3:1] = 3'h6;
    else sw[3:1] = {1'b0, s > 0, s < 0};
    sw[4] = sw[4] | sw[3];
    c = a + b;
    op(CBU_OP_ADD16, 16'h0000, 0);
    rdc(4'h4, {16'hABCD, c});
  endtask
  task freeze;
    @(posedge mclk_i);
    ce_i        <= 0;
    op_valid_i  <= 1;
    op_code_i   <= CBU_OP_JALWAY;
    op_offset_i <= 16'h0040;
    reg_wr_i    <= 1;
    reg_addr_i  <= 4'h8;
    reg_wdata_i <= 32'h0000_1111;
    @(posedge mclk_i);
    op_valid_i <= 0;
    reg_wr_i   <= 0;
    repeat (2) @(posedge mclk_i);
    ce_i <= 1;
    #1 chk(done_o, 0);
    chk(pc_o, pc_m);
  endtask
  task restart;
    @(posedge mclk_i);
    rstn_i <= 0;
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1;
    pc_m = 16'h0000;
    sw   = 16'h0000;
    #1 chk(pc_o, 0);
    chk(status_o, 0);
    chk(irq_o, 0);
    chk(done_o, 0);
    op(CBU_OP_JALWAY, 16'h0003, 1);
  endtask
  // ********************************
  // Scenarios
  // ********************************
  initial begin
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1;
    rdc(4'h1, 32'h0);
    rdc(4'h9, 32'h0);
    sw = 16'h0020;
    wr(4'h1, 32'h20);
    add(16'h0005, 16'hFFFB);
    add(16'hFFFD, 16'h0001);
    add(16'h0064, 16'h00C8);
    add(16'h7FFF, 16'h0001);
    add(16'h8000, 16'hFFFF);
    add(16'h8000, 16'h8000);
    add(16'h0001, 16'h0001);
    rdc(4'h5, 32'h12340001);
    wr(4'h0, 32'h1);
    rdc(4'h0, 32'h1);
    wr(4'h6, 32'h33);
    wr(4'h7, 32'h44);
    add(16'h0002, 16'h0003);
    rdc(4'h5, 32'h33);
    rdc(4'h6, 32'h44);
    rdc(4'h7, 32'h44);
    for (int i = 0; i < 4; i++) begin
      sw = {13'h0, i[1:0], 1'b0};
      wr(4'h1, {16'h0, sw});
      op(CBU_OP_JLEZ, 16'h8000, !i[1]);
      op(CBU_OP_JUNORD, 16'h7FFF, &i[1:0]);
    end
    wr(4'h3, 32'h4);
    wr(4'h2, 32'h7);
    op(CBU_OP_JALWAY, 16'hFFFE, 1);
    @(posedge mclk_i);
    #1 chk(irq_o, 1);
    wr(4'h2, 32'h4);
    @(posedge mclk_i);
    #1 chk(irq_o, 0);
    wr(4'h3, 32'h0);
    for (int i = 6; i < 9; i++) begin
      sw[2:1] = 2'h3;
      if (i < 8) sw[4:3] = 2'h3;
      op(i[3:0], 16'h0000, 0);
    end
    op(CBU_OP_JUNORD, 16'h0010, 1);
    #1 chk(irq_o, 0);
    wr(4'h4, 32'h5A5A0002);
    c = 16'h0002;
    repeat (3) begin
      c = c - 16'h0001;
      op(CBU_OP_LOOP, 16'h0010, c != 0);
      rdc(4'h4, {16'h5A5A, c});
    end
    freeze;
    rdc(4'h8, {16'h0000, pc_m});
    restart;
    final_report;
  end
  initial begin
    repeat (5000) @(posedge mclk_i);
    n_fail++;
    final_report;
  end
endmodule
